// File: verilog/step_translator_pkg.sv
// constants for the step translator and diagnostics block
package step_translator_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] CTRL0_ADDR = 8'h00;
  localparam logic [7:0] CTRL1_ADDR = 8'h04;
  localparam logic [7:0] CTRL2_ADDR = 8'h08;
  localparam logic [7:0] STAT0_ADDR = 8'h10;
  localparam logic [7:0] STAT1_ADDR = 8'h14;
  localparam logic [7:0] STAT2_ADDR = 8'h18;
  localparam logic [7:0] STAT3_ADDR = 8'h1C;
  // control 0 fields
  localparam int CUR_LSB = 0;
  localparam int SM_LSB = 5;
  // control 1 fields
  localparam int BRIDGE_ENABLE_BIT_BIT = 0;
  localparam int ROTATION_SENSE_BIT_BIT = 1;
  localparam int STEP_EDGE_SELECT_BIT = 2;
  // control 2 fields
  localparam int BACKEMF_TRANSPARENT_BIT = 0;
  localparam int BACKEMF_DIVIDER_SELECT_BIT = 1;
  localparam int SLP_BIT = 2;
  // status 0 fields
  localparam int TW_BIT = 0;
  localparam int TSD_BIT = 1;
  localparam int COIL_X_BREAK_FLAG_BIT = 2;
  localparam int COIL_Y_BREAK_FLAG_BIT = 3;
  localparam int CPF_BIT = 4;
  // reset values
  localparam logic [2:0] SM_RESET = 3'h0;
  localparam logic [6:0] POS_RESET = 7'h00;
  // step resolution code 0 is 1/32; code n gives 2^n table entries per step
  localparam logic [2:0] SM_MAX = 3'h5;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int OPEN_TIME_MS = 200;
  localparam int OPEN_CYCLES = OPEN_TIME_MS * CLK_MHZ * 1000;
  // register bus answer: one wait cycle
  localparam int BUS_WAIT = 1;
endpackage : step_translator_pkg

// File: verilog/step_translator_diagnostics.sv
// step translator, back-emf monitor control and latched diagnostics
// Overview of operation
// - direction is pin XOR software sense bit
// - each qualifying step edge moves 2^n entries at resolution code n
// - edge select picks rising or falling edge
// - 7-bit position readable, updated on step
// - new resolution applied at next step
// - finer resolution snaps to nearest grid point
// - coarser resolution keeps offset from grid
// - peak code applied at next PWM period
// - sample back-emf at each zero crossing end while sample-hold is high
// - transparent follows, otherwise hold end sample
// - divider select halves or quarters sample
// - thermal warning sets warning flag
// - shutdown sets flag and disables bridges
// - shutdown flag clears after cool and read
// - overload sets per-transistor flag, bridges off
// - full duty over 200 ms breaks coil
// - pump fault flag follows low pump voltage
// - fault output low on any diagnostic flag
// - hard reset pin clears all registers
// - sleep disables drivers, keeps registers
// - no steps in sleep; wait pump start-up
// - reset to position zero, finest resolution
// - unchanged resolution steps one column entry
// - diagnostic status cleared after status read
// - bridge enable bit gates both bridges
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module step_translator_diagnostics
  import step_translator_pkg::*;
#(
  parameter int OPEN_LIMIT = OPEN_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hardResetPin,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stepPulseInput,
  input wire logic rotationSensePin,
  input wire logic pwmPeriodStart,
  input wire logic pwmFullDutyX,
  input wire logic pwmFullDutyY,
  input wire logic coilXZero,
  input wire logic coilYZero,
  input wire logic pwmSampleHold,
  input wire logic tempWarning,
  input wire logic tempShutdown,
  input wire logic [3:0] overloadX,
  input wire logic [3:0] overloadY,
  input wire logic pumpLow,
  output logic [6:0] translatorPos,
  output logic [4:0] peakAmplitudeCode,
  output logic [2:0] activeResolution,
  output logic bridgeXEnable,
  output logic bridgeYEnable,
  output logic analogPowerDown,
  output logic bemfTrack,
  output logic bemfDivFour,
  output logic faultOut_n
);
  // all asynchronous inputs pass two flops
  localparam int NSYNC = 19;
  logic [NSYNC-1:0] syncA_r;
  logic [NSYNC-1:0] syncB_r;
  logic stepPrev_r;
  logic hardSyncA_r;
  logic hardSyncB_r;
  logic clr;
  always_ff @(posedge ref_clk) begin
    syncA_r <= {stepPulseInput, rotationSensePin, pwmPeriodStart, pwmFullDutyX, pwmFullDutyY, coilXZero,
                coilYZero, pwmSampleHold, tempWarning, tempShutdown, overloadX, overloadY, pumpLow};
    syncB_r <= syncA_r;
    hardSyncA_r <= hardResetPin;
    hardSyncB_r <= hardSyncA_r;
  end
  wire stepS = syncB_r[18];
  wire dirPinS = syncB_r[17];
  wire pwmStartS = syncB_r[16];
  wire fullXS = syncB_r[15];
  wire fullYS = syncB_r[14];
  wire zeroXS = syncB_r[13];
  wire zeroYS = syncB_r[12];
  wire sampleHoldS = syncB_r[11];
  wire warnS = syncB_r[10];
  wire shutS = syncB_r[9];
  wire [3:0] ovxS = syncB_r[8:5];
  wire [3:0] ovyS = syncB_r[4:1];
  wire pumpLowS = syncB_r[0];
  assign clr = rst | hardSyncB_r;

  // control registers
  logic [4:0] curCode_r;
  logic [2:0] smReq_r;
  logic bridge_enable_bit_r;
  logic rotation_sense_bit_r;
  logic step_edge_select_r;
  logic backemf_transparent_r;
  logic backemf_divider_select_r;
  logic slp_r;
  logic busWrite;
  logic readDone;
  logic readStat;
  logic readStat0;
  logic readStat12;
  logic [1:0] busCnt_r;
  logic busAck;
  // one wait state so readdata can come straight from a flop
  assign busAck = (avs_read | avs_write) && busCnt_r == 2'(BUS_WAIT);
  assign busWrite = avs_write && busAck;
  assign readDone = avs_read && busAck;
  assign readStat0 = readDone && avs_address == STAT0_ADDR;
  assign readStat12 = readDone && (avs_address == STAT1_ADDR || avs_address == STAT2_ADDR);
  assign readStat = readStat0 | readStat12;

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      busCnt_r <= 2'h0;
    end else if (busAck) begin
      busCnt_r <= 2'h0;
    end else if (avs_read | avs_write) begin
      busCnt_r <= busCnt_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      curCode_r <= 5'h00;
      smReq_r <= SM_RESET;
      bridge_enable_bit_r <= 1'b0;
      rotation_sense_bit_r <= 1'b0;
      step_edge_select_r <= 1'b0;
      backemf_transparent_r <= 1'b0;
      backemf_divider_select_r <= 1'b0;
      slp_r <= 1'b0;
    end else if (busWrite) begin
      // status addresses fall through: writes there are ignored
      if (avs_address == CTRL0_ADDR) begin
        curCode_r <= avs_writedata[CUR_LSB +: 5];
        smReq_r <= avs_writedata[SM_LSB +: 3];
      end else if (avs_address == CTRL1_ADDR) begin
        bridge_enable_bit_r <= avs_writedata[BRIDGE_ENABLE_BIT_BIT];
        rotation_sense_bit_r <= avs_writedata[ROTATION_SENSE_BIT_BIT];
        step_edge_select_r <= avs_writedata[STEP_EDGE_SELECT_BIT];
      end else if (avs_address == CTRL2_ADDR) begin
        backemf_transparent_r <= avs_writedata[BACKEMF_TRANSPARENT_BIT];
        backemf_divider_select_r <= avs_writedata[BACKEMF_DIVIDER_SELECT_BIT];
        slp_r <= avs_writedata[SLP_BIT];
      end
    end
  end

  // step translator
  logic [2:0] smAct_r;
  logic [6:0] pos_r;
  logic [6:0] posNxt;
  logic [6:0] stepSize;
  logic [6:0] halfSize;
  logic [6:0] gridMask;
  logic [6:0] snapped;
  logic stepEdge;
  logic dirUp;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      stepPrev_r <= 1'b0;
    end else begin
      stepPrev_r <= stepS;
    end
  end
  // edge select: 0 rising, 1 falling
  assign stepEdge = step_edge_select_r ? (stepPrev_r & ~stepS) : (~stepPrev_r & stepS);
  assign dirUp = dirPinS ^ rotation_sense_bit_r;
  always_comb begin
    // codes above the coarsest mode clamp to full step
    stepSize = 7'h01 << ((smReq_r > SM_MAX) ? SM_MAX : smReq_r);
    halfSize = stepSize >> 1;
    gridMask = ~(stepSize - 7'h01);
    posNxt = pos_r;
    if (smReq_r < smAct_r) begin
      // finer grid: snap to nearest point, then step
      snapped = (pos_r + halfSize) & gridMask;
    end else begin
      // same or coarser: any offset from the grid is kept
      snapped = pos_r;
    end
    // wrap past either end comes free from the 7-bit width
    if (dirUp) begin
      posNxt = snapped + stepSize;
    end else begin
      posNxt = snapped - stepSize;
    end
  end
  // steps are ignored in sleep; the controller must not send them anyway
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      pos_r <= POS_RESET;
      smAct_r <= SM_RESET;
    end else if (stepEdge && !slp_r) begin
      pos_r <= posNxt;
      // mode only moves with a step, never on the bus write
      smAct_r <= (smReq_r > SM_MAX) ? SM_MAX : smReq_r;
    end
  end

  // peak current applied at pwm period start
  logic [4:0] curApplied_r;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      curApplied_r <= 5'h00;
    end else if (pwmStartS) begin
      curApplied_r <= curCode_r;
    end
  end

  // back-emf sample control
  logic zeroPrev_r;
  logic track_r;
  wire zeroAny = zeroXS | zeroYS;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      zeroPrev_r <= 1'b0;
      track_r <= 1'b0;
    end else begin
      zeroPrev_r <= zeroAny;
      if (backemf_transparent_r) begin
        track_r <= 1'b1;
      end else begin
        // pulse at end of each zero crossing interval that ends while sample-hold is high
        track_r <= zeroPrev_r & ~zeroAny & sampleHoldS;
      end
    end
  end

  // diagnostics
  logic tw_r;
  logic tsd_r;
  logic [3:0] ovx_r;
  logic [3:0] ovy_r;
  logic coil_x_break_flag_r;
  logic coil_y_break_flag_r;
  logic [31:0] fullCntX_r;
  logic [31:0] fullCntY_r;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      tw_r <= 1'b0;
      tsd_r <= 1'b0;
    end else begin
      // set wins over the clear by read
      tw_r <= warnS | (tw_r & ~readStat0);
      if (shutS) begin
        tsd_r <= 1'b1;
      end else if (readStat && !warnS) begin
        tsd_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ovx_r <= 4'h0;
      ovy_r <= 4'h0;
    end else begin
      // a live overload survives the clearing read
      ovx_r <= ovxS | (ovx_r & {4{~readStat12}});
      ovy_r <= ovyS | (ovy_r & {4{~readStat12}});
    end
  end
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      fullCntX_r <= 32'h0;
      fullCntY_r <= 32'h0;
      coil_x_break_flag_r <= 1'b0;
      coil_y_break_flag_r <= 1'b0;
    end else begin
      // counters saturate so a long full duty cannot wrap to zero
      fullCntX_r <= fullXS ? ((fullCntX_r > 32'(OPEN_LIMIT)) ? fullCntX_r : fullCntX_r + 32'h1) : 32'h0;
      fullCntY_r <= fullYS ? ((fullCntY_r > 32'(OPEN_LIMIT)) ? fullCntY_r : fullCntY_r + 32'h1) : 32'h0;
      coil_x_break_flag_r <= (fullCntX_r > 32'(OPEN_LIMIT)) | (coil_x_break_flag_r & ~readStat0);
      coil_y_break_flag_r <= (fullCntY_r > 32'(OPEN_LIMIT)) | (coil_y_break_flag_r & ~readStat0);
    end
  end
  // pump level is live, not latched
  wire anyFault = tw_r | tsd_r | (|ovx_r) | (|ovy_r) | coil_x_break_flag_r | coil_y_break_flag_r | pumpLowS;
  wire driveOk = bridge_enable_bit_r & ~slp_r & ~tsd_r & ~(|ovx_r) & ~(|ovy_r);

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      translatorPos <= POS_RESET;
      peakAmplitudeCode <= 5'h00;
      activeResolution <= SM_RESET;
      bridgeXEnable <= 1'b0;
      bridgeYEnable <= 1'b0;
      analogPowerDown <= 1'b0;
      bemfTrack <= 1'b0;
      bemfDivFour <= 1'b0;
      faultOut_n <= 1'b1;
    end else begin
      translatorPos <= pos_r;
      peakAmplitudeCode <= curApplied_r;
      activeResolution <= smAct_r;
      bridgeXEnable <= driveOk & ~coil_x_break_flag_r;
      bridgeYEnable <= driveOk & ~coil_y_break_flag_r;
      analogPowerDown <= slp_r;
      bemfTrack <= track_r;
      bemfDivFour <= backemf_divider_select_r;
      faultOut_n <= ~anyFault;
    end
  end

  // bus answer: readdata and waitrequest registered
  // unmapped addresses read as zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (avs_address == CTRL0_ADDR) begin
      rdMux = {24'h0, smReq_r, curCode_r};
    end else if (avs_address == CTRL1_ADDR) begin
      rdMux = {29'h0, step_edge_select_r, rotation_sense_bit_r, bridge_enable_bit_r};
    end else if (avs_address == CTRL2_ADDR) begin
      rdMux = {29'h0, slp_r, backemf_divider_select_r, backemf_transparent_r};
    end else if (avs_address == STAT0_ADDR) begin
      rdMux = {27'h0, pumpLowS, coil_y_break_flag_r, coil_x_break_flag_r, tsd_r, tw_r};
    end else if (avs_address == STAT1_ADDR) begin
      rdMux = {28'h0, ovx_r};
    end else if (avs_address == STAT2_ADDR) begin
      rdMux = {28'h0, ovy_r};
    end else if (avs_address == STAT3_ADDR) begin
      rdMux = {25'h0, pos_r};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_readdata <= rdMux;
      // low exactly in the answer cycle
      avs_waitrequest <= ~((avs_read | avs_write) && busCnt_r == 2'(BUS_WAIT - 1) && !busAck);
    end
  end
endmodule : step_translator_diagnostics

// File: verif/step_translator_monitor.sv
// checker for the step translator and diagnostics block
`timescale 1ns/10ps
module step_translator_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hardResetPin,
  input wire logic tempWarning,
  input wire logic tempShutdown,
  input wire logic pumpLow,
  input wire logic [6:0] translatorPos,
  input wire logic [2:0] activeResolution,
  input wire logic bridgeXEnable,
  input wire logic bridgeYEnable,
  input wire logic analogPowerDown,
  input wire logic faultOut_n
);
  default clocking @(posedge ref_clk);
  endclocking
  // pin reset lags by its synchroniser, so flags stay quiet around it
  default disable iff (rst || hardResetPin);
  a_reset_pos_zero: assert property ($fell(rst) |-> translatorPos == 7'h00 && activeResolution == 3'h0)
    else $error("position not cleared");
  a_step_one_entry: assert property (!$stable(translatorPos) && $stable(activeResolution)
    && activeResolution == $past(activeResolution, 2) |-> 7'(translatorPos - $past(translatorPos))
    inside {7'(7'h01 << activeResolution), 7'(7'h00 - (7'h01 << activeResolution))})
    else $error("wrong step size");
  a_mode_on_step: assert property ($changed(activeResolution) |-> ##[0:2] !$stable(translatorPos))
    else $error("mode changed without step");
  a_sleep_no_step: assert property (analogPowerDown [*6] |-> $stable(translatorPos))
    else $error("step taken in sleep");
  a_sleep_bridges_off: assert property (analogPowerDown && $past(analogPowerDown) |-> !bridgeXEnable && !bridgeYEnable)
    else $error("bridge on in sleep");
  a_shutdown_bridges_off: assert property (tempShutdown [*5] |=> !bridgeXEnable && !bridgeYEnable)
    else $error("bridge on in shutdown");
  a_warn_fault_low: assert property (tempWarning [*5] |=> !faultOut_n)
    else $error("fault high on warning");
  a_pump_fault_low: assert property (pumpLow [*5] |=> !faultOut_n)
    else $error("fault high on pump low");
  cover property ($changed(activeResolution));
  cover property (analogPowerDown [*6]);
  cover property (tempShutdown && !bridgeXEnable);
endmodule : step_translator_monitor

bind step_translator_diagnostics step_translator_monitor step_translator_monitor_inst (.ref_clk, .rst,
  .hardResetPin, .tempWarning, .tempShutdown, .pumpLow, .translatorPos, .activeResolution, .bridgeXEnable,
  .bridgeYEnable, .analogPowerDown, .faultOut_n);

// File: verif/step_pin_model.sv
// controller pin model driving the step and direction lines
`timescale 1ns/10ps
module step_pin_model #(
  parameter int PUMP_WAIT = 16
) (
  input wire logic ref_clk,
  input wire logic sleepOn,
  output logic stepPin,
  output logic dirPin
);
  int awake = 0;
  initial stepPin = 1'h0;
  initial dirPin = 1'h1;
  // cycles since sleep ended; the pump needs them to settle
  always @(posedge ref_clk) awake <= sleepOn ? 0 : awake + 1;
  task automatic lvl(input logic v);
    while (sleepOn || awake < PUMP_WAIT) @(posedge ref_clk);
    stepPin <= v;
    repeat (8) @(posedge ref_clk);
  endtask : lvl
  // direction pin changes only between steps
  task automatic dir(input logic v);
    @(posedge ref_clk);
    dirPin <= v;
    repeat (4) @(posedge ref_clk);
  endtask : dir
endmodule : step_pin_model

// File: verif/tb.sv
// self-checking bench for the step translator block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
  import step_translator_pkg::*;
  logic ref_clk = 1'h0, rst = 1'h1, hardResetPin = 1'h0, avs_read = 1'h0, avs_write = 1'h0, pumpLow = 1'h1;
  logic pwmPeriodStart = 1'h0, coilXZero = 1'h0, coilYZero = 1'h0, pwmSampleHold = 1'h0, tempWarning = 1'h0;
  logic tempShutdown = 1'h0, stepPulseInput, rotationSensePin, avs_waitrequest, analogPowerDown;
  logic [1:0] fullDuty = 2'h0;
  logic [3:0] ov;
  logic [4:0] pk;
  logic [4:0] peakOut;
  logic bemfTrack, bemfDivFour;
  logic [31:0] expd;
  logic [7:0] avs_address = 8'h00, ovl = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q[$];
  int err_count = 0, comparisons = 0, cyc = 0, n;
  always #4 ref_clk = ~ref_clk;
  step_translator_diagnostics #(.OPEN_LIMIT(20)) step_translator_diagnostics_inst (.ref_clk, .rst, .hardResetPin,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .stepPulseInput,
    .rotationSensePin, .pwmPeriodStart, .pwmFullDutyX(fullDuty[0]), .pwmFullDutyY(fullDuty[1]), .coilXZero,
    .coilYZero, .pwmSampleHold, .tempWarning, .tempShutdown, .overloadX(ovl[3:0]), .overloadY(ovl[7:4]), .pumpLow,
    .translatorPos(), .peakAmplitudeCode(peakOut), .activeResolution(), .bridgeXEnable(), .bridgeYEnable(),
    .analogPowerDown, .bemfTrack, .bemfDivFour, .faultOut_n());
  step_pin_model step_pin_model_inst (.ref_clk, .sleepOn(analogPowerDown), .stepPin(stepPulseInput),
    .dirPin(rotationSensePin));
  task automatic test_done();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge ref_clk) begin
    {coilXZero, coilYZero, pwmSampleHold} <= 3'($urandom);
    pwmPeriodStart <= ($urandom % 8) == 0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
    if (!rst && avs_read && avs_waitrequest === 1'h0) begin
      expd = q.pop_front();
      `CHK("avs_readdata", expd, avs_readdata)
    end
  end
  // request held until waitrequest is seen low, then released for one idle cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 40);
    if (k >= 40) err_count++;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(a, 1'h0, 32'h0);
  endtask : rd
  task automatic pulse(input int k);
    repeat (k) begin
      step_pin_model_inst.lvl(1'h1);
      step_pin_model_inst.lvl(1'h0);
    end
  endtask : pulse
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : wt
  initial begin
    n = $urandom(32'hDA28);
    wt(12);
    rst <= 1'h0;
    wt(5);
    rd(CTRL0_ADDR, 32'h0);
    rd(STAT3_ADDR, 32'h0);
    rd(STAT0_ADDR, 32'h10);
    rd(8'h20, 32'h0);
    pumpLow <= 1'h0;
    wt(6);
    rd(STAT0_ADDR, 32'h0);
    $display("reset test done");
    n = 1 + $urandom % 8;
    bus(CTRL1_ADDR, 1'h1, 32'h1);
    pulse(n);
    rd(STAT3_ADDR, 32'(n));
    step_pin_model_inst.dir(1'h0);
    pulse(1);
    rd(STAT3_ADDR, 32'(n - 1));
    step_pin_model_inst.dir(1'h1);
    bus(CTRL1_ADDR, 1'h1, 32'h3);
    pulse(n + 2);
    rd(STAT3_ADDR, 32'h7D);
    bus(CTRL1_ADDR, 1'h1, 32'h7);
    step_pin_model_inst.lvl(1'h1);
    rd(STAT3_ADDR, 32'h7D);
    step_pin_model_inst.lvl(1'h0);
    rd(STAT3_ADDR, 32'h7C);
    bus(CTRL1_ADDR, 1'h1, 32'h5);
    pulse(1);
    $display("step test done");
    pk = 5'($urandom);
    bus(CTRL0_ADDR, 1'h1, {24'h0, 3'h3, pk});
    rd(STAT3_ADDR, 32'h7D);
    pulse(1);
    rd(STAT3_ADDR, 32'h05);
    pulse(1);
    rd(STAT3_ADDR, 32'h0D);
    bus(CTRL0_ADDR, 1'h1, {24'h0, 3'h1, pk});
    pulse(1);
    rd(STAT3_ADDR, 32'h10);
    `CHK("peakAmplitudeCode", pk, peakOut)
    bus(CTRL0_ADDR, 1'h1, {24'h0, 3'h2, pk});
    pulse(1);
    rd(STAT3_ADDR, 32'h14);
    $display("resolution test done");
    tempWarning <= 1'h1;
    wt(8);
    rd(STAT0_ADDR, 32'h1);
    tempShutdown <= 1'h1;
    wt(8);
    tempShutdown <= 1'h0;
    rd(STAT0_ADDR, 32'h3);
    tempWarning <= 1'h0;
    wt(8);
    rd(STAT0_ADDR, 32'h3);
    rd(STAT0_ADDR, 32'h0);
    for (int i = 0; i < 2; i++) begin
      ov = 4'(1 + $urandom % 15);
      ovl <= 8'(ov) << (4 * i);
      wt(6);
      ovl <= 8'h00;
      wt(6);
      rd(8'(STAT1_ADDR + 4 * i), {28'h0, ov});
      rd(8'(STAT1_ADDR + 4 * i), 32'h0);
      fullDuty[i] <= 1'h1;
      wt(30);
      fullDuty[i] <= 1'h0;
      wt(4);
      rd(STAT0_ADDR, 32'h4 << i);
      rd(STAT0_ADDR, 32'h0);
    end
    $display("diagnostics test done");
    n = 1 + 2 * ($urandom % 2);
    bus(CTRL2_ADDR, 1'h1, 32'h4 | 32'(n));
    wt(8);
    `CHK("bemfDivFour", n[1], bemfDivFour)
    `CHK("bemfTrack", 1'h1, bemfTrack)
    rd(STAT3_ADDR, 32'h14);
    bus(CTRL2_ADDR, 1'h1, 32'h0);
    pulse(1);
    rd(STAT3_ADDR, 32'h18);
    hardResetPin <= 1'h1;
    wt(5);
    hardResetPin <= 1'h0;
    wt(4);
    rd(CTRL0_ADDR, 32'h0);
    pulse(1);
    rd(STAT3_ADDR, 32'h1);
    $display("sleep and reset test done");
    test_done();
  end
endmodule : tb
